// File: src/pcs_reg_bank.sv
// Coding-sublayer and medium-attachment register bank of the MAC-PHY.
`timescale 1ns/10ps
module pcs_reg_bank #(
    parameter int unsigned SOFT_RESET_CYCLES = pcs_pkg::SOFT_RESET_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Register access, already unframed from the serial host interface.
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [pcs_pkg::MMS_W-1:0] memory_map_select_i,
    input wire logic [pcs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pcs_pkg::BUS_W-1:0] reg_wdata_i,
    output logic [pcs_pkg::BUS_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Line events from the coding sublayer.
    input wire logic local_jabber_i,
    input wire logic far_babble_i,
    input wire logic phys_collision_i,
    input wire logic logical_collision_i,
    // Writes made through the legacy and management control copies.
    input wire logic alias_soft_reset_i,
    input wire logic alias_loopback_wr_i,
    input wire logic alias_loopback_i,
    // Controls to the sublayers.
    output logic attachment_soft_reset_o,
    output logic transmit_shutdown_o,
    output logic loopback_o
);

    // The length counter only feeds a check below; it must be wide enough for SOFT_RESET_CYCLES.
    localparam int unsigned SRST_LEN_W = 16;
    localparam logic [SRST_LEN_W-1:0] SRST_LEN = SRST_LEN_W'(SOFT_RESET_CYCLES);
    localparam logic [SRST_LEN_W-1:0] SRST_LEN_ONE = {{(SRST_LEN_W-1){1'b0}}, 1'b1};
    localparam logic [pcs_pkg::REG_W-1:0] COUNT_ONE = {{(pcs_pkg::REG_W-1){1'b0}}, 1'b1};

    typedef struct packed {
        logic jabber_fault_flag;
        logic transmit_shutdown;
        logic loopback;
        logic rvalid;
        logic [pcs_pkg::BUS_W-1:0] rdata;
        logic [SRST_LEN_W-1:0] srst_len;
    } pcs_bank_s;

    pcs_bank_s state_q;
    pcs_bank_s state_d;

    pcs_pkg::pcs_sel_e rd_sel;
    pcs_pkg::pcs_sel_e wr_sel;
    logic [pcs_pkg::REG_W-1:0] far_babble_count;
    logic [pcs_pkg::REG_W-1:0] phys_collision_count;
    logic [pcs_pkg::REG_W-1:0] wr_field;
    logic [pcs_pkg::REG_W-1:0] rd_field;
    logic srst_busy;
    logic srst_start;
    logic ctrl_wr;
    logic clr_far;
    logic clr_coll;

    assign rd_sel = reg_rd_i ? pcs_pkg::pcs_decode(memory_map_select_i, reg_addr_i) : pcs_pkg::PCS_SEL_NONE;
    assign wr_sel = reg_wr_i ? pcs_pkg::pcs_decode(memory_map_select_i, reg_addr_i) : pcs_pkg::PCS_SEL_NONE;
    // Only the low half of a write is looked at.
    assign wr_field = reg_wdata_i[pcs_pkg::REG_W-1:0];
    assign ctrl_wr = (wr_sel == pcs_pkg::PCS_SEL_ATT_CTRL);
    // Either copy of the soft reset bit starts the same sequence.
    assign srst_start = (ctrl_wr && wr_field[pcs_pkg::BIT_SOFT_RESET]) || alias_soft_reset_i;
    assign clr_far = (rd_sel == pcs_pkg::PCS_SEL_FAR_BABBLE);
    assign clr_coll = (rd_sel == pcs_pkg::PCS_SEL_PHYS_COLL);

    pcs_sat_counter #(
        .WIDTH(pcs_pkg::REG_W)
    ) u_far_babble (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .event_i(far_babble_i),
        .clear_i(clr_far),
        .count_o(far_babble_count)
    );

    // The arbitration's logical collisions never reach this counter.
    pcs_sat_counter #(
        .WIDTH(pcs_pkg::REG_W)
    ) u_phys_collision (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .event_i(phys_collision_i),
        .clear_i(clr_coll),
        .count_o(phys_collision_count)
    );

    pcs_soft_reset #(
        .HOLD_CYCLES(SOFT_RESET_CYCLES)
    ) u_soft_reset (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(srst_start),
        .busy_o(srst_busy)
    );

    // Read data is formed from the values before this cycle's clears take effect.
    always_comb begin
        rd_field = pcs_pkg::VAL_ZERO;
        case (rd_sel)
            pcs_pkg::PCS_SEL_PRESENCE_ONE: begin
                rd_field = pcs_pkg::VAL_PRESENCE_ONE;
            end
            pcs_pkg::PCS_SEL_PRESENCE_TWO: begin
                rd_field = pcs_pkg::VAL_PRESENCE_TWO;
            end
            pcs_pkg::PCS_SEL_EXT_ABILITY: begin
                rd_field = pcs_pkg::VAL_EXT_ABILITY;
            end
            pcs_pkg::PCS_SEL_CS_STATUS: begin
                rd_field[pcs_pkg::BIT_JABBER_FAULT] = state_q.jabber_fault_flag;
            end
            pcs_pkg::PCS_SEL_FAR_BABBLE: begin
                rd_field = far_babble_count;
            end
            pcs_pkg::PCS_SEL_PHYS_COLL: begin
                rd_field = phys_collision_count;
            end
            pcs_pkg::PCS_SEL_ATT_CTRL: begin
                rd_field = pcs_pkg::RST_ATT_CTRL;
                rd_field[pcs_pkg::BIT_SOFT_RESET] = srst_busy;
                rd_field[pcs_pkg::BIT_TX_SHUTDOWN] = state_q.transmit_shutdown;
                rd_field[pcs_pkg::BIT_LOOPBACK] = state_q.loopback;
            end
            default: begin
                rd_field = pcs_pkg::VAL_ZERO;
            end
        endcase
    end

    always_comb begin
        state_d = state_q;
        state_d.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            state_d.rdata = {pcs_pkg::VAL_UPPER, rd_field};
        end
        // A read clears the flag, but a fault in the same cycle keeps it set.
        if (rd_sel == pcs_pkg::PCS_SEL_CS_STATUS) begin
            state_d.jabber_fault_flag = 1'b0;
        end
        if (local_jabber_i || far_babble_i) begin
            state_d.jabber_fault_flag = 1'b1;
        end
        if (ctrl_wr) begin
            state_d.transmit_shutdown = wr_field[pcs_pkg::BIT_TX_SHUTDOWN];
            state_d.loopback = wr_field[pcs_pkg::BIT_LOOPBACK];
        end
        if (alias_loopback_wr_i) begin
            state_d.loopback = alias_loopback_i;
        end
        // Starting a soft reset returns the attachment controls to their defaults.
        if (srst_start && !srst_busy) begin
            state_d.transmit_shutdown = pcs_pkg::RST_ATT_CTRL[pcs_pkg::BIT_TX_SHUTDOWN];
            state_d.loopback = pcs_pkg::RST_ATT_CTRL[pcs_pkg::BIT_LOOPBACK];
        end
        // Cycles the running soft reset has lasted so far.
        if (srst_busy) begin
            state_d.srst_len = state_q.srst_len + SRST_LEN_ONE;
        end else begin
            state_d.srst_len = '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata_o = state_q.rdata;
    assign reg_rvalid_o = state_q.rvalid;
    assign attachment_soft_reset_o = srst_busy;
    assign transmit_shutdown_o = state_q.transmit_shutdown;
    assign loopback_o = state_q.loopback;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    jabber_set_a: assert property ((local_jabber_i || far_babble_i) |=> state_q.jabber_fault_flag)
        else $error("Jabber fault did not set the flag.");

    jabber_hold_a: assert property (
        state_q.jabber_fault_flag && rd_sel != pcs_pkg::PCS_SEL_CS_STATUS |=> state_q.jabber_fault_flag)
        else $error("Jabber flag dropped without a read.");

    jabber_clear_a: assert property (
        rd_sel == pcs_pkg::PCS_SEL_CS_STATUS && !local_jabber_i && !far_babble_i
        |=> !state_q.jabber_fault_flag && reg_rdata_o[pcs_pkg::BIT_JABBER_FAULT] == $past(state_q.jabber_fault_flag))
        else $error("Jabber flag read did not report and clear.");

    upper_zero_a: assert property (reg_rvalid_o |-> reg_rdata_o[pcs_pkg::BUS_W-1:pcs_pkg::REG_W] == '0)
        else $error("Upper bytes of read data are not zero.");

    read_timing_a: assert property (reg_rd_i |=> reg_rvalid_o ##1 !reg_rvalid_o || $past(reg_rd_i))
        else $error("Read answer did not follow the request by one cycle.");

    presence_one_a: assert property (
        rd_sel == pcs_pkg::PCS_SEL_PRESENCE_ONE |=> reg_rdata_o == 32'h0000000B)
        else $error("First presence register misread.");

    presence_two_a: assert property (
        rd_sel == pcs_pkg::PCS_SEL_PRESENCE_TWO |=> reg_rdata_o == 32'h00000000)
        else $error("Second presence register misread.");

    ability_read_a: assert property (
        rd_sel == pcs_pkg::PCS_SEL_EXT_ABILITY |=> reg_rdata_o == 32'h00000008)
        else $error("Extended ability register misread.");

    shared_bus_a: assert property (
        rd_sel == pcs_pkg::PCS_SEL_ATT_CTRL |=> reg_rdata_o[pcs_pkg::BIT_SHARED_BUS]
            && reg_rdata_o[pcs_pkg::BIT_TX_SHUTDOWN-1:pcs_pkg::BIT_SHARED_BUS+1] == '0)
        else $error("Control register shared bus bit not one.");

    ctrl_reserved_a: assert property (
        rd_sel == pcs_pkg::PCS_SEL_ATT_CTRL
        |=> reg_rdata_o[pcs_pkg::BIT_SHARED_BUS-1:pcs_pkg::BIT_LOOPBACK+1] == '0)
        else $error("Control register reserved bits not zero.");

    ctrl_readback_a: assert property (
        rd_sel == pcs_pkg::PCS_SEL_ATT_CTRL
        |=> reg_rdata_o[pcs_pkg::BIT_SOFT_RESET] == $past(attachment_soft_reset_o)
            && reg_rdata_o[pcs_pkg::BIT_TX_SHUTDOWN] == $past(transmit_shutdown_o)
            && reg_rdata_o[pcs_pkg::BIT_LOOPBACK] == $past(loopback_o))
        else $error("Control register read does not match its controls.");

    status_reserved_a: assert property (
        rd_sel == pcs_pkg::PCS_SEL_CS_STATUS
        |=> reg_rdata_o[pcs_pkg::REG_W-1:pcs_pkg::BIT_JABBER_FAULT+1] == '0
            && reg_rdata_o[pcs_pkg::BIT_JABBER_FAULT-1:0] == '0)
        else $error("Status register reserved bits not zero.");

    unmapped_read_a: assert property (
        reg_rd_i && rd_sel == pcs_pkg::PCS_SEL_NONE |=> reg_rdata_o == '0)
        else $error("Unmapped register did not read zero.");

    rvalid_only_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("Read answer without a read request.");

    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("Read data changed without a read.");

    jabber_cause_a: assert property (
        !state_q.jabber_fault_flag && !local_jabber_i && !far_babble_i |=> !state_q.jabber_fault_flag)
        else $error("Jabber flag set without a fault.");

    far_read_a: assert property (
        clr_far |=> reg_rdata_o[pcs_pkg::REG_W-1:0] == $past(far_babble_count))
        else $error("Remote jabber count misread.");

    far_clear_a: assert property (clr_far && !far_babble_i |=> far_babble_count == '0)
        else $error("Remote jabber count did not clear on read.");

    far_count_a: assert property (
        far_babble_i && !clr_far && far_babble_count != '1
        |=> far_babble_count == $past(far_babble_count) + COUNT_ONE)
        else $error("Remote jabber event not counted.");

    coll_read_a: assert property (
        clr_coll |=> reg_rdata_o[pcs_pkg::REG_W-1:0] == $past(phys_collision_count))
        else $error("Collision count misread.");

    coll_count_a: assert property (
        phys_collision_i && !clr_coll && phys_collision_count != '1
        |=> phys_collision_count == $past(phys_collision_count) + COUNT_ONE)
        else $error("Physical collision not counted.");

    soft_reset_start_a: assert property (srst_start && !srst_busy |=> attachment_soft_reset_o)
        else $error("Soft reset did not start.");

    srst_defaults_a: assert property (
        srst_start && !srst_busy |=> !transmit_shutdown_o && !loopback_o)
        else $error("Soft reset did not restore the controls.");

    srst_length_a: assert property ($fell(srst_busy) |-> state_q.srst_len == SRST_LEN)
        else $error("Soft reset did not last its hold time.");

    shutdown_write_a: assert property (
        ctrl_wr && !srst_start && !alias_loopback_wr_i
        |=> transmit_shutdown_o == $past(wr_field[pcs_pkg::BIT_TX_SHUTDOWN])
            && loopback_o == $past(wr_field[pcs_pkg::BIT_LOOPBACK]))
        else $error("Control write did not take effect.");

    shutdown_hold_a: assert property (
        !ctrl_wr && !(srst_start && !srst_busy) |=> $stable(transmit_shutdown_o))
        else $error("Transmitter shutdown changed without a write.");

    loop_alias_a: assert property (
        alias_loopback_wr_i && !srst_start |=> loopback_o == $past(alias_loopback_i))
        else $error("Loopback alias write lost.");

    logical_only_a: assert property (
        logical_collision_i && !phys_collision_i && !clr_coll |=> $stable(phys_collision_count))
        else $error("Logical collision was counted.");

endmodule

// File: inc/pcs_pkg.sv
// Shared constants, register map and address decode for the coding-sublayer register bank.
package pcs_pkg;

    // Register word and meaningful field widths.
    localparam int unsigned BUS_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned MMS_W = 4;
    localparam int unsigned ADDR_W = 16;

    // Memory map selections that hold these registers.
    localparam logic [MMS_W-1:0] MMS_PCS = 4'h2;
    localparam logic [MMS_W-1:0] MMS_PMA = 4'h3;

    // Register offsets inside a memory map selection.
    localparam logic [ADDR_W-1:0] OFS_PRESENCE_ONE = 16'h0005;
    localparam logic [ADDR_W-1:0] OFS_PRESENCE_TWO = 16'h0006;
    localparam logic [ADDR_W-1:0] OFS_EXT_ABILITY = 16'h0012;
    localparam logic [ADDR_W-1:0] OFS_CS_STATUS = 16'h08F4;
    localparam logic [ADDR_W-1:0] OFS_FAR_BABBLE = 16'h08F5;
    localparam logic [ADDR_W-1:0] OFS_PHYS_COLL = 16'h08F6;
    localparam logic [ADDR_W-1:0] OFS_ATT_CTRL = 16'h08F9;

    // Field positions.
    localparam int unsigned BIT_JABBER_FAULT = 7;
    localparam int unsigned BIT_SOFT_RESET = 15;
    localparam int unsigned BIT_TX_SHUTDOWN = 14;
    localparam int unsigned BIT_SHARED_BUS = 10;
    localparam int unsigned BIT_LOOPBACK = 0;

    // Constant register contents and reset values.
    localparam logic [REG_W-1:0] VAL_PRESENCE_ONE = 16'h000B;
    localparam logic [REG_W-1:0] VAL_PRESENCE_TWO = 16'h0000;
    localparam logic [REG_W-1:0] VAL_EXT_ABILITY = 16'h0008;
    localparam logic [REG_W-1:0] RST_ATT_CTRL = 16'h0400;
    localparam logic [REG_W-1:0] VAL_ZERO = 16'h0000;
    localparam logic [BUS_W-REG_W-1:0] VAL_UPPER = 16'h0000;

    // Soft reset duration and clock.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SOFT_RESET_NS = 1000;
    localparam int unsigned SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PCS_SEL_NONE,
        PCS_SEL_PRESENCE_ONE,
        PCS_SEL_PRESENCE_TWO,
        PCS_SEL_EXT_ABILITY,
        PCS_SEL_CS_STATUS,
        PCS_SEL_FAR_BABBLE,
        PCS_SEL_PHYS_COLL,
        PCS_SEL_ATT_CTRL
    } pcs_sel_e;

    // Presence registers exist in both selections; the rest in one each.
    function automatic pcs_sel_e pcs_decode(input logic [MMS_W-1:0] memory_map_select, input logic [ADDR_W-1:0] addr);
        pcs_sel_e sel;
        sel = PCS_SEL_NONE;
        if (memory_map_select == MMS_PCS || memory_map_select == MMS_PMA) begin
            if (addr == OFS_PRESENCE_ONE) sel = PCS_SEL_PRESENCE_ONE;
            if (addr == OFS_PRESENCE_TWO) sel = PCS_SEL_PRESENCE_TWO;
        end
        if (memory_map_select == MMS_PCS) begin
            if (addr == OFS_CS_STATUS) sel = PCS_SEL_CS_STATUS;
            if (addr == OFS_FAR_BABBLE) sel = PCS_SEL_FAR_BABBLE;
            if (addr == OFS_PHYS_COLL) sel = PCS_SEL_PHYS_COLL;
        end
        if (memory_map_select == MMS_PMA) begin
            if (addr == OFS_EXT_ABILITY) sel = PCS_SEL_EXT_ABILITY;
            if (addr == OFS_ATT_CTRL) sel = PCS_SEL_ATT_CTRL;
        end
        return sel;
    endfunction

endpackage

// File: src/pcs_sat_counter.sv
// Saturating event counter that clears when read.
`timescale 1ns/10ps
module pcs_sat_counter #(
    parameter int unsigned WIDTH = pcs_pkg::REG_W
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic event_i,
    input wire logic clear_i,
    output logic [WIDTH-1:0] count_o
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } pcs_cnt_s;

    localparam logic [WIDTH-1:0] CNT_MAX = '1;
    localparam logic [WIDTH-1:0] CNT_ZERO = '0;
    localparam logic [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    pcs_cnt_s state_q;
    pcs_cnt_s state_d;

    // An event in the cycle of the clearing read is kept as the first count after it.
    always_comb begin
        state_d = state_q;
        if (clear_i) begin
            state_d.count = event_i ? CNT_ONE : CNT_ZERO;
        end else if (event_i && state_q.count != CNT_MAX) begin
            state_d.count = state_q.count + CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign count_o = state_q.count;

    cnt_saturate_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q.count == CNT_MAX && !clear_i |=> state_q.count == CNT_MAX)
        else $error("Counter left its saturated value.");

    cnt_clear_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        clear_i && !event_i |=> state_q.count == CNT_ZERO)
        else $error("Counter did not clear on read.");

endmodule

// File: src/pcs_soft_reset.sv
// Soft reset sequencer: holds the reset for a fixed time, then releases it.
`timescale 1ns/10ps
module pcs_soft_reset #(
    parameter int unsigned HOLD_CYCLES = pcs_pkg::SOFT_RESET_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    output logic busy_o
);

    typedef struct packed {
        logic busy;
        logic [15:0] left;
    } pcs_srst_s;

    localparam logic [15:0] HOLD_LOAD = 16'(HOLD_CYCLES - 1);
    localparam logic [15:0] LEFT_ONE = 16'h0001;

    pcs_srst_s state_q;
    pcs_srst_s state_d;

    // A start while busy is absorbed; the running reset already covers it.
    always_comb begin
        state_d = state_q;
        if (!state_q.busy) begin
            if (start_i) begin
                state_d.busy = 1'b1;
                state_d.left = HOLD_LOAD;
            end
        end else if (state_q.left == '0) begin
            state_d.busy = 1'b0;
        end else begin
            state_d.left = state_q.left - LEFT_ONE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign busy_o = state_q.busy;

    srst_release_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        state_q.busy && state_q.left != '0 |=> state_q.busy)
        else $error("Soft reset released before its hold time.");

endmodule

// File: tb/pcs_host_model.sv
// Host model that issues whole-word register reads and writes to the bank.
`timescale 1ns/10ps
module pcs_host_model (
    input wire logic sys_clk_i,
    input wire logic [pcs_pkg::BUS_W-1:0] rdata_i,
    input wire logic rvalid_i,
    output logic rd_o,
    output logic wr_o,
    output logic [pcs_pkg::MMS_W-1:0] mms_o,
    output logic [pcs_pkg::ADDR_W-1:0] addr_o,
    output logic [pcs_pkg::BUS_W-1:0] wdata_o
);
    initial begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        mms_o = 4'h0;
        addr_o = 16'h0000;
        wdata_o = 32'h0000_0000;
    end

    // Callers enter just after a rising edge; one idle cycle follows each write, three follow each read.
    task automatic wr(input logic [3:0] m, input logic [15:0] a, input logic [31:0] d);
        mms_o = m;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge sys_clk_i) #1;
        wr_o = 1'b0;
        @(posedge sys_clk_i) #1;
    endtask

    task automatic rd(input logic [3:0] m, input logic [15:0] a, output logic [31:0] d, output logic ok);
        mms_o = m;
        addr_o = a;
        rd_o = 1'b1;
        ok = 1'b0;
        d = 32'h0000_0000;
        @(posedge sys_clk_i) #1;
        rd_o = 1'b0;
        repeat (3) begin
            if (!ok && rvalid_i === 1'b1) begin
                d = rdata_i;
                ok = 1'b1;
            end
            @(posedge sys_clk_i) #1;
        end
    endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the coding-sublayer register bank.
`timescale 1ns/10ps
module tb;
    localparam int SRC = 8;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] evt = 4'h0;
    logic srst_a = 1'b0;
    logic lb_wr = 1'b0;
    logic lb_v = 1'b0;
    logic rd, wr, rvalid, busy, shut, loop;
    logic [3:0] memory_map_select;
    logic [15:0] addr;
    logic [31:0] wdata, rdata;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int busy_run = 0;
    int busy_len = 0;

    always #5 sys_clk = ~sys_clk;

    // Measured on the falling edge, away from the edge that moves the soft reset output.
    always @(negedge sys_clk) begin
        if (busy === 1'b1) begin
            busy_run++;
        end else if (busy_run != 0) begin
            busy_len = busy_run;
            busy_run = 0;
        end
    end

    pcs_host_model host (.sys_clk_i(sys_clk), .rdata_i(rdata), .rvalid_i(rvalid), .rd_o(rd), .wr_o(wr),
        .mms_o(memory_map_select), .addr_o(addr), .wdata_o(wdata));

    pcs_reg_bank #(.SOFT_RESET_CYCLES(SRC)) dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .reg_rd_i(rd),
        .reg_wr_i(wr), .memory_map_select_i(memory_map_select), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .local_jabber_i(evt[0]), .far_babble_i(evt[1]), .phys_collision_i(evt[2]),
        .logical_collision_i(evt[3]), .alias_soft_reset_i(srst_a), .alias_loopback_wr_i(lb_wr),
        .alias_loopback_i(lb_v), .attachment_soft_reset_o(busy), .transmit_shutdown_o(shut), .loopback_o(loop));

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The saturation test alone needs about 65600 cycles.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic rchk(input string nm, input logic [3:0] m, input logic [15:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic ok;
        host.rd(m, a, d, ok);
        chk1({nm, " valid"}, 1'b1, ok);
        chk32(nm, e, d);
    endtask

    task automatic ev(input logic [3:0] k, input int n);
        evt = k;
        repeat (n) @(posedge sys_clk) #1;
        evt = 4'h0;
        @(posedge sys_clk) #1;
    endtask

    task automatic t_reset();
        chk1("shutdown", 1'b0, shut);
        chk1("loopback", 1'b0, loop);
        rchk("presence1 pcs", 4'h2, 16'h0005, 32'h0000_000B);
        rchk("presence1 pma", 4'h3, 16'h0005, 32'h0000_000B);
        rchk("presence2", 4'h3, 16'h0006, 32'h0000_0000);
        rchk("ability", 4'h3, 16'h0012, 32'h0000_0008);
        rchk("control", 4'h3, 16'h08F9, 32'h0000_0400);
        rchk("status", 4'h2, 16'h08F4, 32'h0000_0000);
        rchk("unmapped", 4'h3, 16'h08F4, 32'h0000_0000);
        host.wr(4'h2, 16'h0005, 32'hFFFF_FFFF);
        rchk("presence1 ro", 4'h2, 16'h0005, 32'h0000_000B);
        $display("reset values done");
    endtask

    task automatic t_jabber();
        ev(4'h1, 1);
        rchk("local jab", 4'h2, 16'h08F4, 32'h0000_0080);
        rchk("jab cleared", 4'h2, 16'h08F4, 32'h0000_0000);
        ev(4'h2, 2);
        repeat (5) @(posedge sys_clk) #1;
        rchk("far jab held", 4'h2, 16'h08F4, 32'h0000_0080);
        rchk("far count", 4'h2, 16'h08F5, 32'h0000_0002);
        rchk("far cleared", 4'h2, 16'h08F5, 32'h0000_0000);
        $display("jabber done");
    endtask

    task automatic t_coll();
        ev(4'h8, 5);
        ev(4'h4, 3);
        rchk("collisions", 4'h2, 16'h08F6, 32'h0000_0003);
        rchk("coll cleared", 4'h2, 16'h08F6, 32'h0000_0000);
        ev(4'h4, 65537);
        rchk("coll sat", 4'h2, 16'h08F6, 32'h0000_FFFF);
        rchk("sat cleared", 4'h2, 16'h08F6, 32'h0000_0000);
        $display("collisions done");
    endtask

    task automatic t_ctrl();
        host.wr(4'h3, 16'h08F9, 32'hABCD_4201);
        chk1("shutdown on", 1'b1, shut);
        chk1("loop on", 1'b1, loop);
        rchk("control set", 4'h3, 16'h08F9, 32'h0000_4401);
        host.wr(4'h3, 16'h08F9, 32'h0000_0000);
        chk1("shutdown off", 1'b0, shut);
        rchk("control clr", 4'h3, 16'h08F9, 32'h0000_0400);
        lb_v = 1'b1;
        lb_wr = 1'b1;
        @(posedge sys_clk) #1;
        lb_wr = 1'b0;
        chk1("alias loop", 1'b1, loop);
        rchk("control alias", 4'h3, 16'h08F9, 32'h0000_0401);
        lb_v = 1'b0;
        lb_wr = 1'b1;
        @(posedge sys_clk) #1;
        lb_wr = 1'b0;
        chk1("alias loop off", 1'b0, loop);
        $display("control done");
    endtask

    task automatic srst_end();
        int n;
        n = 0;
        while (busy === 1'b1 && n < SRC + 6) begin
            @(posedge sys_clk) #1;
            n++;
        end
        chk1("reset ends", 1'b0, busy);
        rchk("control after", 4'h3, 16'h08F9, 32'h0000_0400);
        chk32("reset length", SRC, busy_len);
    endtask

    task automatic t_srst();
        host.wr(4'h3, 16'h08F9, 32'h0000_C001);
        chk1("soft busy", 1'b1, busy);
        chk1("shutdown reset", 1'b0, shut);
        rchk("control busy", 4'h3, 16'h08F9, 32'h0000_8400);
        srst_end();
        srst_a = 1'b1;
        @(posedge sys_clk) #1;
        srst_a = 1'b0;
        chk1("alias busy", 1'b1, busy);
        rchk("alias read", 4'h3, 16'h08F9, 32'h0000_8400);
        srst_end();
        $display("soft reset done");
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        @(posedge sys_clk) #1;
        t_reset();
        t_jabber();
        t_coll();
        t_ctrl();
        t_srst();
        wrap_up();
    end
endmodule
